/* File: rtl/tbt_bcast_filter.v */
// decides whether a broadcast applies and with which scope and vmid
`timescale 1ns/10ps
`include "tbt_regs.vh"
module tbt_bcast_filter #(
  parameter S1_IMPL = 1,
  parameter S2_IMPL = 1,
  parameter SEC_IMPL = 1,
  parameter BTM_IMPL = 1,
  parameter WIDE_VMID_CAPABLE_IMPL = 1
) (
  // incoming message
  input wire [`TBT_WORLD_W-1:0] msg_world,
  input wire [1:0] msg_scope,
  input wire [`TBT_TAG_W-1:0] msg_vmid,
  input wire msg_sender_has_hyp,
  // private maintenance controls
  input wire private_tlb_maintenance_ns,
  input wire private_tlb_maintenance_s,
  // verdict
  output wire drop,
  output wire s1_eff,
  output wire s2_eff,
  output wire [`TBT_TAG_W-1:0] vmid_eff
);
  wire secure_msg;
  wire ptm_hit;

  assign secure_msg = (msg_world == `TBT_W_SEC) || (msg_world == `TBT_W_MON);
  // private maintenance silences one security state only
  assign ptm_hit = secure_msg ? private_tlb_maintenance_s : private_tlb_maintenance_ns;
  // combined scope keeps whatever stage exists
  assign s1_eff = msg_scope[`TBT_SC_S1] && (S1_IMPL != 0);
  assign s2_eff = msg_scope[`TBT_SC_S2] && (S2_IMPL != 0);
  assign drop = (BTM_IMPL == 0) || ptm_hit || (secure_msg && SEC_IMPL == 0)
    || !(s1_eff || s2_eff);
  // zero vmid when stage two is absent or the sender has no hypervisor
  assign vmid_eff = (S2_IMPL == 0 || !msg_sender_has_hyp) ? `TBT_ZERO_TAG :
    ((WIDE_VMID_CAPABLE_IMPL != 0) ? msg_vmid : {`TBT_ZERO_HI, msg_vmid[`TBT_NARROW_W-1:0]});
endmodule // tbt_bcast_filter

/* File: rtl/tbt_fill_tagger.v */
// tag forming for fills and lookups: width masking and world gating
`timescale 1ns/10ps
`include "tbt_regs.vh"
module tbt_fill_tagger #(
  parameter S2_IMPL = 1,
  parameter WIDE_VMID_CAPABLE_IMPL = 1,
  parameter WIDE_ASID_CAPABLE_IMPL = 1
) (
  // context of the translation
  input wire [`TBT_WORLD_W-1:0] world,
  input wire [`TBT_TAG_W-1:0] cd_asid,
  input wire [`TBT_TAG_W-1:0] ste_vmid,
  // formed tags
  output wire [`TBT_TAG_W-1:0] tag_asid,
  output wire [`TBT_TAG_W-1:0] tag_vmid
);
  wire has_vmid;
  wire has_asid;
  wire [`TBT_TAG_W-1:0] vmid_w;
  wire [`TBT_TAG_W-1:0] asid_w;

  // worlds that carry each tag
  assign has_vmid = (world == `TBT_W_NSK) || (world == `TBT_W_SEC);
  assign has_asid = (world == `TBT_W_NSK) || (world == `TBT_W_SEC) || (world == `TBT_W_HYPH);
  // narrow tags keep the upper byte at zero so compares stay exact
  assign vmid_w = (WIDE_VMID_CAPABLE_IMPL != 0) ? ste_vmid : {`TBT_ZERO_HI, ste_vmid[`TBT_NARROW_W-1:0]};
  assign asid_w = (WIDE_ASID_CAPABLE_IMPL != 0) ? cd_asid : {`TBT_ZERO_HI, cd_asid[`TBT_NARROW_W-1:0]};
  assign tag_vmid = (S2_IMPL != 0 && has_vmid) ? vmid_w : `TBT_ZERO_TAG;
  assign tag_asid = has_asid ? asid_w : `TBT_ZERO_TAG;
endmodule // tbt_fill_tagger

/* File: rtl/tbt_regs.vh */
// constants for the tagged tlb with broadcast invalidate filtering
// Overview of operation
// - vmid tags 16 bits only when wide capable
// - nonsecure kernel entries carry vmid tag when stage two exists
// - vmid tag taken from stream entry field
// - no stage two means no vmid stored
// - broadcast support reported by read-only bit
// - private maintenance bit drops broadcasts per state
// - drop unimplemented stage, keep implemented combined part
// - no stage two: broadcasts match vmid zero
// - sender without hypervisor level sends vmid zero
// - address set entries may skip asid-matching broadcasts
// - shared entries hit by every matching broadcast
// - address set never affects stage two entries
// - lookups and commands ignore address set for asid
// - address set checked for global lookup hits
// - asid ignored in hypervisor and monitor worlds
// - hypervisor set entries survive by-address, not all
// - monitor set entries survive by-address, not all
// - asid-less worlds share one address space
// - host-mode broadcast leaves plain hypervisor entries
// - asid tags 16 bits only when wide capable
// - every entry tagged with world, asid if present
// - global entries match same world, vmid and set, any asid
`ifndef TBT_REGS_VH
`define TBT_REGS_VH
// translation worlds
`define TBT_WORLD_W 3
`define TBT_W_NSK 3'h0
`define TBT_W_SEC 3'h1
`define TBT_W_HYP 3'h2
`define TBT_W_HYPH 3'h3
`define TBT_W_MON 3'h4
// invalidate operations, broadcast and command alike
`define TBT_OP_W 3
`define TBT_OP_VA 3'h0
`define TBT_OP_VAA 3'h1
`define TBT_OP_ASID 3'h2
`define TBT_OP_ALL 3'h3
`define TBT_OP_IPA 3'h4
// stage scope bit positions
`define TBT_SC_S1 0
`define TBT_SC_S2 1
// tag widths
`define TBT_TAG_W 16
`define TBT_NARROW_W 8
`define TBT_ZERO_HI 8'h00
`define TBT_ZERO_TAG 16'h0000
`endif

/* File: rtl/tbt_tlb.v */
// tagged translation tlb with fill, lookup, command and broadcast invalidation
`timescale 1ns/10ps
`include "tbt_regs.vh"
module tbt_tlb #(
  parameter ENTRIES = 8,
  parameter IDX_W = 3,
  parameter ADDR_W = 20,
  parameter S1_IMPL = 1,
  parameter S2_IMPL = 1,
  parameter SEC_IMPL = 1,
  parameter BTM_IMPL = 1,
  parameter WIDE_VMID_CAPABLE_IMPL = 1,
  parameter WIDE_ASID_CAPABLE_IMPL = 1
) (
  // clock and reset
  input wire clock,
  input wire resetn,
  // capability bits
  output wire stage_two_capable,
  output wire wide_vmid_capable,
  output wire wide_asid_capable,
  output wire broadcast_invalidate_capable,
  // control
  input wire translation_unit_enable,
  input wire private_tlb_maintenance_ns,
  input wire private_tlb_maintenance_s,
  // fill from the walker
  input wire fill_valid,
  output wire fill_ready,
  input wire [`TBT_WORLD_W-1:0] fill_world,
  input wire fill_ipa,
  input wire fill_global,
  input wire [ADDR_W-1:0] fill_addr,
  input wire [`TBT_TAG_W-1:0] fill_cd_asid,
  input wire fill_address_set_flag,
  input wire [`TBT_TAG_W-1:0] fill_stream_entry_vmid_field,
  // lookup
  input wire lk_valid,
  input wire [`TBT_WORLD_W-1:0] lk_world,
  input wire lk_ipa,
  input wire [ADDR_W-1:0] lk_addr,
  input wire [`TBT_TAG_W-1:0] lk_cd_asid,
  input wire lk_address_set_flag,
  input wire [`TBT_TAG_W-1:0] lk_stream_entry_vmid_field,
  output wire lk_resp_valid,
  output wire lk_hit,
  output wire [IDX_W-1:0] lk_index,
  // software invalidate commands
  input wire cmd_valid,
  input wire [`TBT_OP_W-1:0] cmd_op,
  input wire [`TBT_WORLD_W-1:0] cmd_world,
  input wire [ADDR_W-1:0] cmd_addr,
  input wire [`TBT_TAG_W-1:0] cmd_asid,
  input wire [`TBT_TAG_W-1:0] cmd_vmid,
  output wire cmd_done,
  // broadcast invalidate messages
  input wire bc_valid,
  output wire bc_ready,
  input wire [`TBT_OP_W-1:0] bc_op,
  input wire [`TBT_WORLD_W-1:0] bc_world,
  input wire [1:0] bc_scope,
  input wire [ADDR_W-1:0] bc_addr,
  input wire [`TBT_TAG_W-1:0] bc_asid,
  input wire [`TBT_TAG_W-1:0] bc_vmid,
  input wire bc_sender_has_hyp,
  output wire bc_done,
  output wire bc_dropped
);
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_APPLY = 2'h2;

  // entry storage
  reg [ENTRIES-1:0] valid_reg;
  reg [`TBT_WORLD_W-1:0] world_mem [0:ENTRIES-1];
  reg ipa_mem [0:ENTRIES-1];
  reg global_mem [0:ENTRIES-1];
  reg address_set_flag_mem [0:ENTRIES-1];
  reg [`TBT_TAG_W-1:0] asid_mem [0:ENTRIES-1];
  reg [`TBT_TAG_W-1:0] vmid_mem [0:ENTRIES-1];
  reg [ADDR_W-1:0] addr_mem [0:ENTRIES-1];
  // broadcast state and latched message
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg m_drop_reg;
  reg m_s1_reg;
  reg m_s2_reg;
  reg [`TBT_OP_W-1:0] m_op_reg;
  reg [`TBT_WORLD_W-1:0] m_world_reg;
  reg [ADDR_W-1:0] m_addr_reg;
  reg [`TBT_TAG_W-1:0] m_asid_reg;
  reg [`TBT_TAG_W-1:0] m_vmid_reg;
  reg bc_done_reg;
  reg bc_dropped_reg;
  reg cmd_done_reg;
  reg lk_resp_valid_reg;
  reg lk_hit_reg;
  reg [IDX_W-1:0] lk_index_reg;
  reg [IDX_W-1:0] victim_reg;
  // combinational results
  reg [ENTRIES-1:0] bc_kill;
  reg [ENTRIES-1:0] cmd_kill;
  reg [ENTRIES-1:0] lk_match;
  reg lk_any;
  reg [IDX_W-1:0] lk_idx;
  reg free_any;
  reg [IDX_W-1:0] free_idx;
  wire [IDX_W-1:0] fill_idx;
  wire fill_take;
  wire bc_take;
  wire apply_now;
  wire [`TBT_TAG_W-1:0] f_asid;
  wire [`TBT_TAG_W-1:0] f_vmid;
  wire [`TBT_TAG_W-1:0] l_asid;
  wire [`TBT_TAG_W-1:0] l_vmid;
  wire f_drop;
  wire f_s1;
  wire f_s2;
  wire [`TBT_TAG_W-1:0] f_bvmid;
  wire [`TBT_TAG_W-1:0] b_asid;
  integer i, j;
  // worlds that carry an asid tag
  function has_asid;
    input [`TBT_WORLD_W-1:0] w;
    has_asid = (w == `TBT_W_NSK) || (w == `TBT_W_SEC) || (w == `TBT_W_HYPH);
  endfunction
  // worlds that carry a vmid tag
  function has_vmid;
    input [`TBT_WORLD_W-1:0] w;
    has_vmid = (w == `TBT_W_NSK) || (w == `TBT_W_SEC);
  endfunction

  // one entry against one invalidation; use_address_set_flag only for broadcasts
  function inv_match;
    input ev;
    input [`TBT_WORLD_W-1:0] ew;
    input eipa, eg, ea;
    input [`TBT_TAG_W-1:0] easid, evmid;
    input [ADDR_W-1:0] eaddr;
    input [`TBT_OP_W-1:0] op;
    input [`TBT_WORLD_W-1:0] w;
    input s1, s2;
    input [ADDR_W-1:0] addr;
    input [`TBT_TAG_W-1:0] asid, vmid;
    input use_address_set_flag;
    reg base, skip, s1_hit;
    begin
      // exact world compare, so host-mode messages miss plain hypervisor entries
      base = ev && (ew == w) && (!has_vmid(w) || evmid == vmid) && (eipa ? s2 : s1);
      // the set flag only ever protects stage one entries
      skip = use_address_set_flag && ea && !eipa;
      s1_hit = base && !eipa;
      case (op)
        `TBT_OP_VA: inv_match = s1_hit && (eaddr == addr) && !skip
          && (eg || !has_asid(w) || easid == asid);
        // asid worlds must honour this op; asid-less worlds may skip it
        `TBT_OP_VAA: inv_match = s1_hit && (eaddr == addr)
          && !(skip && !has_asid(w));
        `TBT_OP_ASID: inv_match = s1_hit && !eg && has_asid(w)
          && (easid == asid) && !skip;
        `TBT_OP_IPA: inv_match = base && eipa && (eaddr == addr);
        `TBT_OP_ALL: inv_match = base;
        default: inv_match = 1'b0;
      endcase
    end
  endfunction

  // capability bits are fixed by build parameters
  assign stage_two_capable = (S2_IMPL != 0);
  assign wide_vmid_capable = (S2_IMPL != 0) && (WIDE_VMID_CAPABLE_IMPL != 0);
  assign wide_asid_capable = (S1_IMPL != 0) && (WIDE_ASID_CAPABLE_IMPL != 0);
  assign broadcast_invalidate_capable = (BTM_IMPL != 0);

  // tag forming for fills and for lookups share the same rules
  tbt_fill_tagger #(
    .S2_IMPL(S2_IMPL),
    .WIDE_VMID_CAPABLE_IMPL(WIDE_VMID_CAPABLE_IMPL),
    .WIDE_ASID_CAPABLE_IMPL(WIDE_ASID_CAPABLE_IMPL)
  ) u_fill_tag (
    .world(fill_world),
    .cd_asid(fill_cd_asid),
    .ste_vmid(fill_stream_entry_vmid_field),
    .tag_asid(f_asid),
    .tag_vmid(f_vmid)
  );

  tbt_fill_tagger #(
    .S2_IMPL(S2_IMPL),
    .WIDE_VMID_CAPABLE_IMPL(WIDE_VMID_CAPABLE_IMPL),
    .WIDE_ASID_CAPABLE_IMPL(WIDE_ASID_CAPABLE_IMPL)
  ) u_lk_tag (
    .world(lk_world),
    .cd_asid(lk_cd_asid),
    .ste_vmid(lk_stream_entry_vmid_field),
    .tag_asid(l_asid),
    .tag_vmid(l_vmid)
  );

  // broadcast asid masked like stored tags
  tbt_fill_tagger #(
    .S2_IMPL(S2_IMPL),
    .WIDE_VMID_CAPABLE_IMPL(WIDE_VMID_CAPABLE_IMPL),
    .WIDE_ASID_CAPABLE_IMPL(WIDE_ASID_CAPABLE_IMPL)
  ) u_bc_tag (
    .world(bc_world),
    .cd_asid(bc_asid),
    .ste_vmid(bc_vmid),
    .tag_asid(b_asid),
    .tag_vmid()
  );

  tbt_bcast_filter #(
    .S1_IMPL(S1_IMPL),
    .S2_IMPL(S2_IMPL),
    .SEC_IMPL(SEC_IMPL),
    .BTM_IMPL(BTM_IMPL),
    .WIDE_VMID_CAPABLE_IMPL(WIDE_VMID_CAPABLE_IMPL)
  ) u_filter (
    .msg_world(bc_world),
    .msg_scope(bc_scope),
    .msg_vmid(bc_vmid),
    .msg_sender_has_hyp(bc_sender_has_hyp),
    .private_tlb_maintenance_ns(private_tlb_maintenance_ns),
    .private_tlb_maintenance_s(private_tlb_maintenance_s),
    .drop(f_drop),
    .s1_eff(f_s1),
    .s2_eff(f_s2),
    .vmid_eff(f_bvmid)
  );

  // handshakes; fills wait while any invalidation is in flight
  assign bc_ready = state_reg[0];
  assign bc_take = bc_valid && bc_ready;
  assign apply_now = state_reg[1] && !m_drop_reg;
  assign fill_ready = translation_unit_enable && !apply_now && !cmd_valid;
  assign fill_take = fill_valid && fill_ready;
  assign fill_idx = free_any ? free_idx : victim_reg;

  // per-entry invalidation and lookup compare
  always @* begin
    bc_kill = {ENTRIES{1'b0}};
    cmd_kill = {ENTRIES{1'b0}};
    lk_match = {ENTRIES{1'b0}};
    for (i = 0; i < ENTRIES; i = i + 1) begin
      bc_kill[i] = apply_now && inv_match(valid_reg[i], world_mem[i], ipa_mem[i],
        global_mem[i], address_set_flag_mem[i], asid_mem[i], vmid_mem[i], addr_mem[i],
        m_op_reg, m_world_reg, m_s1_reg, m_s2_reg, m_addr_reg, m_asid_reg,
        m_vmid_reg, 1'b1);
      // commands remove matches whatever the set flag says
      cmd_kill[i] = cmd_valid && inv_match(valid_reg[i], world_mem[i], ipa_mem[i],
        global_mem[i], address_set_flag_mem[i], asid_mem[i], vmid_mem[i], addr_mem[i],
        cmd_op, cmd_world, 1'b1, 1'b1, cmd_addr, cmd_asid, cmd_vmid, 1'b0);
      // global hits need the same set; non-global ignore it; asid-less worlds share space
      lk_match[i] = valid_reg[i] && (world_mem[i] == lk_world)
        && (ipa_mem[i] == lk_ipa) && (addr_mem[i] == lk_addr)
        && (!has_vmid(lk_world) || vmid_mem[i] == l_vmid)
        && (!has_asid(lk_world) || ipa_mem[i]
        || (global_mem[i] ? address_set_flag_mem[i] == lk_address_set_flag
        : asid_mem[i] == l_asid));
    end
  end

  // first hit and first free slot
  always @* begin
    lk_any = 1'b0;
    lk_idx = {IDX_W{1'b0}};
    free_any = 1'b0;
    free_idx = {IDX_W{1'b0}};
    for (j = ENTRIES - 1; j >= 0; j = j - 1) begin // own index, scans never retrigger
      if (lk_match[j]) begin
        lk_any = 1'b1;
        lk_idx = j[IDX_W-1:0];
      end
      if (!valid_reg[j]) begin
        free_any = 1'b1;
        free_idx = j[IDX_W-1:0];
      end
    end
  end

  // broadcast sequencer
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (bc_take) begin
          state_next = ST_APPLY;
        end
      end
      ST_APPLY: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end
  // valid bits, control and registered answers
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      valid_reg <= {ENTRIES{1'b0}};
      state_reg <= ST_IDLE;
      victim_reg <= {IDX_W{1'b0}};
      bc_done_reg <= 1'b0;
      bc_dropped_reg <= 1'b0;
      cmd_done_reg <= 1'b0;
      lk_resp_valid_reg <= 1'b0;
      lk_hit_reg <= 1'b0;
      lk_index_reg <= {IDX_W{1'b0}};
    end else begin
      state_reg <= state_next;
      valid_reg <= valid_reg & ~bc_kill & ~cmd_kill;
      if (fill_take) begin
        valid_reg[fill_idx] <= 1'b1;
        // round robin only advances when it chose the slot
        if (!free_any) begin
          victim_reg <= (victim_reg == ENTRIES - 1) ? {IDX_W{1'b0}} : victim_reg + 1'b1;
        end
      end
      bc_done_reg <= state_reg[1];
      bc_dropped_reg <= state_reg[1] && m_drop_reg;
      cmd_done_reg <= cmd_valid;
      lk_resp_valid_reg <= lk_valid;
      // a disabled unit translates nothing from the tlb
      lk_hit_reg <= lk_valid && lk_any && translation_unit_enable;
      lk_index_reg <= lk_idx;
    end
  end

  // latched broadcast message, already filtered
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      m_drop_reg <= 1'b1;
      m_s1_reg <= 1'b0;
      m_s2_reg <= 1'b0;
      m_op_reg <= `TBT_OP_VA;
      m_world_reg <= `TBT_W_NSK;
      m_addr_reg <= {ADDR_W{1'b0}};
      m_asid_reg <= `TBT_ZERO_TAG;
      m_vmid_reg <= `TBT_ZERO_TAG;
    end else if (bc_take) begin
      m_drop_reg <= f_drop;
      m_s1_reg <= f_s1;
      m_s2_reg <= f_s2;
      m_op_reg <= bc_op;
      m_world_reg <= bc_world;
      m_addr_reg <= bc_addr;
      m_asid_reg <= b_asid;
      m_vmid_reg <= f_bvmid;
    end
  end

  // entry payload; no reset needed since valid gates every use
  always @(posedge clock) begin
    if (fill_take) begin
      world_mem[fill_idx] <= fill_world;
      ipa_mem[fill_idx] <= fill_ipa;
      global_mem[fill_idx] <= fill_global && has_asid(fill_world) && !fill_ipa;
      // stage two entries carry no set flag
      address_set_flag_mem[fill_idx] <= fill_address_set_flag && !fill_ipa;
      asid_mem[fill_idx] <= f_asid;
      vmid_mem[fill_idx] <= f_vmid;
      addr_mem[fill_idx] <= fill_addr;
    end
  end

  assign bc_done = bc_done_reg;
  assign bc_dropped = bc_dropped_reg;
  assign cmd_done = cmd_done_reg;
  assign lk_resp_valid = lk_resp_valid_reg;
  assign lk_hit = lk_hit_reg;
  assign lk_index = lk_index_reg;
endmodule // tbt_tlb

/* File: verification/tbt_bc_model.sv */
// stand-in for the cores that send broadcast invalidations
`timescale 1ns/10ps
`include "tbt_regs.vh"
module tbt_bc_model (
  // clock and answers from the tlb
  input wire clock,
  input wire bc_ready,
  input wire bc_done,
  input wire bc_dropped,
  // message towards the tlb
  output reg bc_valid,
  output reg [`TBT_OP_W-1:0] bc_op,
  output reg [`TBT_WORLD_W-1:0] bc_world,
  output reg [1:0] bc_scope,
  output reg [19:0] bc_addr,
  output reg [`TBT_TAG_W-1:0] bc_asid,
  output reg [`TBT_TAG_W-1:0] bc_vmid,
  output reg bc_sender_has_hyp
);
  // idle cycles before each message, raised for a slow sender
  integer gap = 0;
  initial begin
    bc_valid = 1'b0;
    {bc_op, bc_world, bc_scope, bc_addr, bc_asid, bc_vmid, bc_sender_has_hyp} = '0;
  end
  // fields held up to the ready edge, then inverted so no stale copy lingers
  task send(input [2:0] op, w, input [1:0] sc, input [19:0] a, input [15:0] as, v,
    input h, output dr, output ok);
    integer n;
    begin
      n = 0;
      repeat (gap) @(posedge clock);
      @(posedge clock);
      bc_valid <= 1'b1;
      {bc_op, bc_world, bc_scope, bc_addr} <= {op, w, sc, a};
      {bc_asid, bc_vmid, bc_sender_has_hyp} <= {as, v, h};
      @(negedge clock);
      while (bc_ready !== 1'b1 && n < 20) begin
        @(negedge clock);
        n = n + 1;
      end
      @(posedge clock);
      bc_valid <= 1'b0;
      {bc_op, bc_world, bc_scope, bc_addr} <= ~{op, w, sc, a};
      {bc_asid, bc_vmid, bc_sender_has_hyp} <= ~{as, v, h};
      while (bc_done !== 1'b1 && n < 20) begin
        @(negedge clock);
        n = n + 1;
      end
      dr = bc_dropped;
      ok = n < 20;
    end
  endtask
endmodule // tbt_bc_model

/* File: verification/tbt_tlb_assertions.sv */
// concurrent checks on the tlb ports
`timescale 1ns/10ps
`include "tbt_regs.vh"
module tbt_tlb_chk (
  // clock and reset
  input wire clock,
  input wire resetn,
  // capabilities and controls
  input wire stage_two_capable,
  input wire wide_vmid_capable,
  input wire broadcast_invalidate_capable,
  input wire private_tlb_maintenance_ns,
  input wire private_tlb_maintenance_s,
  // lookup and command
  input wire lk_valid,
  input wire lk_resp_valid,
  input wire cmd_valid,
  input wire cmd_done,
  // broadcast
  input wire bc_valid,
  input wire bc_ready,
  input wire [`TBT_WORLD_W-1:0] bc_world,
  input wire [1:0] bc_scope,
  input wire bc_done,
  input wire bc_dropped
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // a taken message and the private bit of its security state
  wire take = bc_valid && bc_ready;
  wire sec = (bc_world == `TBT_W_SEC) || (bc_world == `TBT_W_MON);
  wire private_tlb_maintenance = sec ? private_tlb_maintenance_s : private_tlb_maintenance_ns;
  AST_CAP_VMID: assert property (wide_vmid_capable |-> stage_two_capable)
    else $error("wide vmid without stage two");
  AST_CAP_BTM: assert property ($stable(broadcast_invalidate_capable))
    else $error("broadcast capability moved");
  AST_LK_RESP: assert property (lk_valid |=> lk_resp_valid)
    else $error("lookup without response");
  AST_CMD_DONE: assert property (cmd_valid |=> cmd_done)
    else $error("command without done");
  AST_BC_SEQ: assert property (take |=> (!bc_ready && !bc_done) ##1 (bc_ready && bc_done))
    else $error("broadcast handshake out of step");
  AST_BC_CAUSE: assert property (bc_done |-> $past(take, 2))
    else $error("done without a taken message");
  AST_BC_DROP: assert property (bc_dropped |-> bc_done)
    else $error("drop flag without done");
  AST_PTM: assert property (take && private_tlb_maintenance |-> ##2 bc_dropped)
    else $error("private state message not dropped");
  AST_NO_SCOPE: assert property (take && bc_scope == 2'h0 |-> ##2 bc_dropped)
    else $error("stageless message not dropped");
  AST_KEEP: assert property (take && !private_tlb_maintenance && bc_scope != 2'h0 |-> ##2 !bc_dropped)
    else $error("legal message dropped");
  // main scenarios reached
  cover property (take ##2 bc_dropped);
  cover property (take ##2 (bc_done && !bc_dropped));
  cover property (cmd_done);
endmodule // tbt_tlb_chk
bind tbt_tlb tbt_tlb_chk u_chk (.*);

/* File: verification/tbt_tlb_test.sv */
// self-checking bench for the tagged tlb
`timescale 1ns/10ps
`include "tbt_regs.vh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("ERROR %0t: got %h expected %h", $time, (a), (e)); end end
module tbt_tlb_test;
  localparam [15:0] V = 16'h0207;
  // clock, reset and controls
  logic clock = '0, resetn = '0, translation_unit_enable = '1;
  logic private_tlb_maintenance_ns = '0, private_tlb_maintenance_s = '0;
  // requests driven by the bench
  logic fill_valid = '0, fill_ipa = '0, fill_global = '0, fill_address_set_flag = '0;
  logic lk_valid = '0, lk_ipa = '0, lk_address_set_flag = '0, cmd_valid = '0;
  logic [2:0] fill_world = '0, lk_world = '0, cmd_op = '0, cmd_world = '0;
  logic [19:0] fill_addr = '0, lk_addr = '0, cmd_addr = '0;
  logic [15:0] fill_cd_asid = '0, fill_stream_entry_vmid_field = '0, lk_cd_asid = '0;
  logic [15:0] lk_stream_entry_vmid_field = '0, cmd_asid = '0, cmd_vmid = '0;
  // answers and broadcast lines
  wire stage_two_capable, wide_vmid_capable, wide_asid_capable, broadcast_invalidate_capable;
  wire fill_ready, lk_resp_valid, lk_hit, cmd_done, bc_ready, bc_done, bc_dropped;
  wire bc_valid, bc_sender_has_hyp;
  wire [2:0] lk_index, bc_op, bc_world;
  wire [1:0] bc_scope;
  wire [19:0] bc_addr;
  wire [15:0] bc_asid, bc_vmid;
  integer fails = 0, checked = 0;
  tbt_tlb dut (.*);
  tbt_bc_model bcm (.*);
  // 100 MHz system clock
  always #5 clock = ~clock;
  task summarize;
    begin
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task tend(input string s);
    $display("test %s done", s);
  endtask
  // fill, held until ready is seen before the taking edge
  task f(input [2:0] w, input i, g, input [19:0] a, input [15:0] as, input s,
    input [15:0] v);
    integer n;
    begin
      n = 0;
      @(posedge clock);
      fill_valid <= 1'b1;
      {fill_world, fill_ipa, fill_global, fill_addr} <= {w, i, g, a};
      {fill_cd_asid, fill_address_set_flag, fill_stream_entry_vmid_field} <= {as, s, v};
      @(negedge clock);
      while (fill_ready !== 1'b1 && n < 20) begin
        @(negedge clock);
        n = n + 1;
      end
      @(posedge clock);
      fill_valid <= 1'b0;
      `CHK(n < 20, 1'b1)
      if (n == 20) summarize;
    end
  endtask
  // lookup, answer registered on the taking edge and checked at the next negedge
  task l(input [2:0] w, input i, input [19:0] a, input [15:0] as, input s,
    input [15:0] v, input e);
    begin
      @(posedge clock);
      lk_valid <= 1'b1;
      {lk_world, lk_ipa, lk_addr, lk_cd_asid} <= {w, i, a, as};
      {lk_address_set_flag, lk_stream_entry_vmid_field} <= {s, v};
      @(posedge clock);
      lk_valid <= 1'b0;
      @(negedge clock);
      `CHK({lk_resp_valid, lk_hit}, {1'b1, e})
    end
  endtask
  // software command, done one cycle later
  task c(input [2:0] op, w, input [19:0] a, input [15:0] as, v);
    begin
      @(posedge clock);
      cmd_valid <= 1'b1;
      {cmd_op, cmd_world, cmd_addr, cmd_asid, cmd_vmid} <= {op, w, a, as, v};
      @(posedge clock);
      cmd_valid <= 1'b0;
      @(negedge clock);
      `CHK(cmd_done, 1'b1)
    end
  endtask
  // broadcast through the sender model, d is the expected drop flag
  task b(input [2:0] op, w, input [1:0] sc, input [19:0] a, input [15:0] as, v,
    input h, d);
    logic dr, ok;
    begin
      bcm.send(op, w, sc, a, as, v, h, dr, ok);
      `CHK({ok, dr}, {1'b1, d})
      if (!ok) summarize;
    end
  endtask
  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    `CHK(stage_two_capable, 1'b1)
    `CHK(wide_vmid_capable, 1'b1)
    `CHK(wide_asid_capable, 1'b1)
    `CHK(broadcast_invalidate_capable, 1'b1)
    tend("caps");
    // full-width tags on a shared entry
    f(`TBT_W_NSK, 0, 0, 20'h1, 16'h0105, 0, V);
    l(`TBT_W_NSK, 0, 20'h1, 16'h0105, 0, V, 1);
    l(`TBT_W_NSK, 0, 20'h1, 16'h0105, 0, 16'h0007, 0);
    l(`TBT_W_NSK, 0, 20'h1, 16'h0005, 0, V, 0);
    l(`TBT_W_NSK, 0, 20'h1, 16'h0105, 1, V, 1);
    l(`TBT_W_SEC, 0, 20'h1, 16'h0105, 0, V, 0);
    b(`TBT_OP_VA, `TBT_W_NSK, 1, 20'h1, 16'h0105, V, 1, 0);
    l(`TBT_W_NSK, 0, 20'h1, 16'h0105, 0, V, 0);
    tend("tags");
    // non-shared entry skips only asid-matching broadcasts
    f(`TBT_W_NSK, 0, 0, 20'h2, 16'h0105, 1, V);
    b(`TBT_OP_VA, `TBT_W_NSK, 1, 20'h2, 16'h0105, V, 1, 0);
    b(`TBT_OP_ASID, `TBT_W_NSK, 1, 20'h2, 16'h0105, V, 1, 0);
    l(`TBT_W_NSK, 0, 20'h2, 16'h0105, 1, V, 1);
    b(`TBT_OP_VAA, `TBT_W_NSK, 1, 20'h2, 16'h0, V, 1, 0);
    l(`TBT_W_NSK, 0, 20'h2, 16'h0105, 1, V, 0);
    tend("address_set_flag");
    // private maintenance per state, sender without hypervisor level
    f(`TBT_W_NSK, 0, 0, 20'h3, 16'h1, 0, 16'h0);
    f(`TBT_W_NSK, 0, 0, 20'h3, 16'h1, 0, V);
    @(posedge clock) {private_tlb_maintenance_ns, private_tlb_maintenance_s} <= 2'h2;
    b(`TBT_OP_ALL, `TBT_W_NSK, 3, 20'h0, 16'h0, V, 1, 1);
    l(`TBT_W_NSK, 0, 20'h3, 16'h1, 0, V, 1);
    `CHK(lk_index, 3'h1)
    @(posedge clock) {private_tlb_maintenance_ns, private_tlb_maintenance_s} <= 2'h1;
    b(`TBT_OP_VA, `TBT_W_NSK, 1, 20'h3, 16'h1, V, 0, 0);
    l(`TBT_W_NSK, 0, 20'h3, 16'h1, 0, 16'h0, 0);
    l(`TBT_W_NSK, 0, 20'h3, 16'h1, 0, V, 1);
    b(`TBT_OP_ALL, `TBT_W_SEC, 3, 20'h0, 16'h0, V, 1, 1);
    @(posedge clock) {private_tlb_maintenance_ns, private_tlb_maintenance_s} <= 2'h0;
    b(`TBT_OP_ALL, `TBT_W_NSK, 3, 20'h0, 16'h0, V, 1, 0);
    l(`TBT_W_NSK, 0, 20'h3, 16'h1, 0, V, 0);
    tend("ptm");
    // asid-less worlds with a slow sender
    bcm.gap = 3;
    f(`TBT_W_HYP, 0, 0, 20'h4, 16'h3, 1, 16'h0);
    l(`TBT_W_HYP, 0, 20'h4, 16'h9, 1, 16'h0, 1);
    b(`TBT_OP_VAA, `TBT_W_HYP, 1, 20'h4, 16'h0, 16'h0, 1, 0);
    b(`TBT_OP_VA, `TBT_W_HYP, 1, 20'h4, 16'h0, 16'h0, 1, 0);
    b(`TBT_OP_ALL, `TBT_W_HYPH, 1, 20'h0, 16'h0, 16'h0, 1, 0);
    l(`TBT_W_HYP, 0, 20'h4, 16'h3, 1, 16'h0, 1);
    b(`TBT_OP_ALL, `TBT_W_HYP, 1, 20'h0, 16'h0, 16'h0, 1, 0);
    l(`TBT_W_HYP, 0, 20'h4, 16'h3, 1, 16'h0, 0);
    f(`TBT_W_MON, 0, 0, 20'h4, 16'h3, 1, 16'h0);
    b(`TBT_OP_VA, `TBT_W_MON, 1, 20'h4, 16'h0, 16'h0, 1, 0);
    l(`TBT_W_MON, 0, 20'h4, 16'h7, 1, 16'h0, 1);
    b(`TBT_OP_ALL, `TBT_W_MON, 1, 20'h0, 16'h0, 16'h0, 1, 0);
    l(`TBT_W_MON, 0, 20'h4, 16'h7, 1, 16'h0, 0);
    bcm.gap = 0;
    tend("worlds");
    // command ignores set flag, stage two scope handling
    f(`TBT_W_NSK, 0, 0, 20'h5, 16'h7, 1, V);
    c(`TBT_OP_VA, `TBT_W_NSK, 20'h5, 16'h7, V);
    l(`TBT_W_NSK, 0, 20'h5, 16'h7, 1, V, 0);
    f(`TBT_W_NSK, 1, 0, 20'h6, 16'h0, 1, V);
    b(`TBT_OP_IPA, `TBT_W_NSK, 0, 20'h6, 16'h0, V, 1, 1);
    l(`TBT_W_NSK, 1, 20'h6, 16'h5, 0, V, 1);
    b(`TBT_OP_IPA, `TBT_W_NSK, 3, 20'h6, 16'h0, V, 1, 0);
    l(`TBT_W_NSK, 1, 20'h6, 16'h5, 0, V, 0);
    tend("cmd_scope");
    // global entries need same world and set
    f(`TBT_W_NSK, 0, 1, 20'h7, 16'h0, 0, V);
    l(`TBT_W_NSK, 0, 20'h7, 16'h63, 0, V, 1);
    l(`TBT_W_NSK, 0, 20'h7, 16'h63, 1, V, 0);
    l(`TBT_W_HYPH, 0, 20'h7, 16'h63, 0, 16'h0, 0);
    @(posedge clock) translation_unit_enable <= 1'b0;
    l(`TBT_W_NSK, 0, 20'h7, 16'h63, 0, V, 0);
    tend("global");
    summarize;
  end
endmodule // tbt_tlb_test
